// File: verilog/pmr_pkg.sv
// constants and types of the program memory read port
// Function
// R1: writing one to control bit 0 starts a read at the current address
// R2: trigger bit clears only by hardware on completion; software zero ignored
// R3: with trigger at zero no read starts and data registers hold
// R4: control bit 7 reserved, always reads one; software keeps it set
// R5: control bits 6 to 1 read zero, writes ignored
// R6: data high bits 7 and 6 read zero
// R7: after read, data high bits 5-0 hold word bits 13-8
// R8: after read, data low holds word bits 7-0
// R9: address joins high and low registers; data written before trigger clears
// R10: data registers writable by software; later read overwrites them
package pmr_pkg;
	// ==========================================================
	// register map
	localparam logic [2:0] PMR_ADDR_CONTROL = 3'h0;
	localparam logic [2:0] PMR_ADDR_DATA_HIGH = 3'h1;
	localparam logic [2:0] PMR_ADDR_DATA_LOW = 3'h2;
	localparam logic [2:0] PMR_ADDR_ADDR_HIGH = 3'h3;
	localparam logic [2:0] PMR_ADDR_ADDR_LOW = 3'h4;
	// ==========================================================
	// fields
	localparam int PMR_TRIG_BIT = 0;
	localparam int PMR_RSVD_BIT = 7;
	localparam int PMR_WORD_W = 14;
	localparam int PMR_AW = 13;
	localparam int PMR_DEPTH = 8192;
	localparam int PMR_HIGH_W = 6;
	localparam int PMR_LOW_W = 8;
	localparam int PMR_ADRH_W = 5;
	localparam logic [7:0] PMR_ZERO8 = 8'h00;
	localparam logic [PMR_WORD_W-1:0] PMR_WORD_ZERO = 14'h0000;
	// ==========================================================
	// read sequencer
	typedef enum logic [1:0] {PMR_IDLE, PMR_FETCH, PMR_LOAD} pmr_state_t;
endpackage

// File: verilog/pmr_mem_if.sv
// memory access signals between sequencer and array
`timescale 1ns/10ps
`default_nettype none
interface pmr_mem_if;
	import pmr_pkg::*;
	logic rd_en;
	logic [PMR_AW-1:0] addr;
	logic [PMR_WORD_W-1:0] rdata;
	modport ctl (output rd_en, output addr, input rdata);
	modport mem (input rd_en, input addr, output rdata);
endinterface
`default_nettype wire

// File: verilog/pmr_array.sv
// program memory array with one registered read port
`timescale 1ns/10ps
`default_nettype none
module pmr_array
	import pmr_pkg::*;
(
	// clock
	input wire logic ref_clk,
	// access
	pmr_mem_if.mem bus
);
	// contents come from the programmer; zero-filled here for simulation
	logic [PMR_WORD_W-1:0] mem_q [PMR_DEPTH];

	initial
	begin
		for (int i = 0; i < PMR_DEPTH; i++)
			mem_q[i] = PMR_WORD_ZERO;
	end

	always_ff @(posedge ref_clk)
	begin
		if (bus.rd_en)
			bus.rdata <= mem_q[bus.addr];
	end
endmodule
`default_nettype wire

// File: verilog/pmr_top.sv
// program memory read port with register interface
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module pmr_top
	import pmr_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// register port
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// status
	output logic busy
);
	// ==========================================================
	// state
	pmr_mem_if mem ();
	pmr_state_t state_q;
	logic trig_q;
	logic [PMR_HIGH_W-1:0] data_high_q;
	logic [7:0] data_low_q;
	logic [PMR_ADRH_W-1:0] addr_high_q;
	logic [7:0] addr_low_q;
	logic wr_ctl;
	logic load;

	assign wr_ctl = reg_wr && reg_addr == PMR_ADDR_CONTROL;
	assign load = state_q == PMR_LOAD;

	pmr_array u_array (
		.ref_clk(ref_clk),
		.bus(mem)
	);

	// ==========================================================
	// trigger bit and sequencer
	// a set on the load edge wins, so that request is not lost and starts the next read
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			trig_q <= 1'b0;
		else if (wr_ctl && reg_wdata[PMR_TRIG_BIT])
			trig_q <= 1'b1; // [R1] [R2]
		else if (load)
			trig_q <= 1'b0; // [R2]
	end

	// a set during an active read before the load cycle is absorbed: trigger already high
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			state_q <= PMR_IDLE;
		else
		begin
			unique case (state_q)
				PMR_IDLE:
					if (trig_q)
						state_q <= PMR_FETCH; // [R1] [R3]
				PMR_FETCH:
					state_q <= PMR_LOAD;
				PMR_LOAD:
					state_q <= PMR_IDLE;
			endcase
		end
	end

	assign mem.rd_en = state_q == PMR_IDLE && trig_q; // [R3]
	assign mem.addr = {addr_high_q, addr_low_q}; // [R9]

	// address captured at the fetch edge; writes during a read affect the next one
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			addr_high_q <= '0;
			addr_low_q <= PMR_ZERO8;
		end
		else if (reg_wr && reg_addr == PMR_ADDR_ADDR_HIGH)
			addr_high_q <= reg_wdata[PMR_ADRH_W-1:0];
		else if (reg_wr && reg_addr == PMR_ADDR_ADDR_LOW)
			addr_low_q <= reg_wdata;
	end

	// ==========================================================
	// data registers
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			data_high_q <= '0;
			data_low_q <= PMR_ZERO8;
		end
		else if (load)
		begin
			data_high_q <= mem.rdata[PMR_WORD_W-1:PMR_LOW_W]; // [R7] [R9] [R10]
			data_low_q <= mem.rdata[PMR_LOW_W-1:0]; // [R8] [R9]
		end
		else if (reg_wr && reg_addr == PMR_ADDR_DATA_HIGH)
			data_high_q <= reg_wdata[PMR_HIGH_W-1:0]; // [R10]
		else if (reg_wr && reg_addr == PMR_ADDR_DATA_LOW)
			data_low_q <= reg_wdata; // [R10]
	end

	// ==========================================================
	// read back
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			reg_rdata <= PMR_ZERO8;
		else if (reg_rd)
		begin
			unique case (reg_addr)
				PMR_ADDR_CONTROL:
					reg_rdata <= {1'b1, 6'h00, trig_q}; // [R4] [R5]
				PMR_ADDR_DATA_HIGH:
					reg_rdata <= {2'h0, data_high_q}; // [R6]
				PMR_ADDR_DATA_LOW:
					reg_rdata <= data_low_q;
				PMR_ADDR_ADDR_HIGH:
					reg_rdata <= {3'h0, addr_high_q};
				PMR_ADDR_ADDR_LOW:
					reg_rdata <= addr_low_q;
				default:
					reg_rdata <= PMR_ZERO8;
			endcase
		end
		else
			reg_rdata <= PMR_ZERO8;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			busy <= 1'b0;
		else
			busy <= trig_q && !load;
	end
endmodule
`default_nettype wire

// File: test/pmr_flash_model.sv
// behavioural content of the program memory array
`timescale 1ns/10ps
`default_nettype none
module pmr_flash_model;
	// pattern differs per address so a wrong fetch or swapped half shows
	function automatic logic [13:0] word_at(input logic [12:0] a);
		return {a[5:0] ^ 6'h2A, a[12:5]};
	endfunction
endmodule
`default_nettype wire

// File: test/pmr_top_properties.sv
// assertions on the program memory read port
`timescale 1ns/10ps
`default_nettype none
module pmr_props (
	// watched ports
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic busy
);
	// ==========
	// properties
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_ctl; reg_rd && reg_addr == 3'h0 |=> reg_rdata[7:1] == 7'h40; endproperty
	a_ctl: assert property (p_ctl) else $error("ctl bits");
	property p_hi; reg_rd && reg_addr == 3'h1 |=> reg_rdata[7:6] == 2'h0; endproperty
	a_hi: assert property (p_hi) else $error("high bits");
	property p_go; reg_wr && reg_addr == 3'h0 && reg_wdata[0] && !busy |=> ##1 busy; endproperty
	a_go: assert property (p_go) else $error("no start");
	property p_end; $rose(busy) |=> busy ##1 !busy; endproperty
	a_end: assert property (p_end) else $error("no finish");
	property p_on; reg_rd && reg_addr == 3'h0 && $rose(busy) |=> reg_rdata[0]; endproperty
	a_on: assert property (p_on) else $error("trigger low");
	// guard on the last write: a trigger set one cycle ago is not yet in busy
	property p_off; reg_rd && reg_addr == 3'h0 && !busy && !$past(reg_wr)
		|=> !reg_rdata[0]; endproperty
	a_off: assert property (p_off) else $error("trigger high");
	property p_nul; reg_wr && reg_addr == 3'h0 && !reg_wdata[0] && !busy && !$past(reg_wr)
		|=> ##1 !busy; endproperty
	a_nul: assert property (p_nul) else $error("zero started");
	property p_idl; !busy && !$past(reg_wr) |=> !busy; endproperty
	a_idl: assert property (p_idl) else $error("self start");
endmodule
bind pmr_top pmr_props u_props (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .busy);
`default_nettype wire

// File: test/tb.sv
// testbench of the program memory read port
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic ref_clk = 1'h0;
	logic rst = 1'h1;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic [7:0] reg_rdata;
	logic busy;
	logic [13:0] w;
	logic [12:0] a;
	logic [12:0] addrs [3] = '{13'h1FFF, 13'h0000, 13'h0A5C};
	int err_total = 0;
	int comparisons = 0;
	pmr_top dut (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .busy);
	pmr_flash_model u_flash ();
	initial
		forever #20 ref_clk = ~ref_clk;
	task automatic cyc(input logic wr, input logic rd, input logic [2:0] ad, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= wr;
		reg_rd <= rd;
		reg_addr <= ad;
		reg_wdata <= d;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rdc(input logic [2:0] ad, input logic [7:0] exp);
		cyc(1'h0, 1'h1, ad, 8'h00);
		cyc(1'h0, 1'h0, ad, 8'h00);
		#1 chk(reg_rdata, exp);
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(posedge ref_clk);
		rst <= 1'h0;
		rdc(3'h0, 8'h80);
		cyc(1'h1, 1'h0, 3'h0, 8'hFE);
		rdc(3'h0, 8'h80);
		rdc(3'h2, 8'h00);
		$display("defaults done");
		foreach (addrs[i])
		begin
			a = addrs[i];
			w = u_flash.word_at(a);
			dut.u_array.mem_q[a] = w;
			cyc(1'h1, 1'h0, 3'h3, {3'h0, a[12:8]});
			cyc(1'h1, 1'h0, 3'h4, a[7:0]);
			rdc(3'h3, {3'h0, a[12:8]});
			rdc(3'h4, a[7:0]);
			cyc(1'h1, 1'h0, 3'h1, 8'hFF);
			rdc(3'h1, 8'h3F);
			cyc(1'h1, 1'h0, 3'h0, 8'h81);
			cyc(1'h0, 1'h0, 3'h0, 8'h00);
			rdc(3'h0, 8'h81);
			chk({7'h00, busy}, 8'h01);
			rdc(3'h0, 8'h80);
			chk({7'h00, busy}, 8'h00);
			rdc(3'h1, {2'h0, w[13:8]});
			rdc(3'h2, w[7:0]);
			cyc(1'h1, 1'h0, 3'h2, 8'h5A);
			cyc(1'h1, 1'h0, 3'h0, 8'h80);
			repeat (4) cyc(1'h0, 1'h0, 3'h0, 8'h00);
			rdc(3'h2, 8'h5A);
			$display("read %h done", a);
		end
		give_verdict();
	end
	initial
	begin
		repeat (2000) @(posedge ref_clk);
		err_total++;
		give_verdict();
	end
endmodule
`default_nettype wire
